// File: core/flash_ctrl_map.svh
// flash_ctrl_map.svh: addresses, command codes and counts of the flash
// controller. assumes inclusion by bare name, definitions only.
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH
// register offsets on the plain register port
`define REG_FCTL    4'h0
`define REG_PSEL    4'h1
// flash control register commands
`define CMD_RESET   8'h00
`define CMD_KEY1    8'h73
`define CMD_KEY2    8'h8C
`define CMD_ERASE   8'h95
// debug memory opcodes
`define OP_WR_PMEM  8'h0A
`define OP_RD_PMEM  8'h0B
`define OP_WR_DMEM  8'h0C
`define OP_RD_DMEM  8'h0D
// data and layout
`define ERASED_BYTE 8'hFF
`define NO_BYTE     8'h00
`define PAGE_LAST   9'h1FF
`define OFF_ONE     9'h001
`define PAGE_HI     15:9
`define SECT_SEL    6:4
`define LO_BYTE     7:0
`define ADDR_ONE    16'h0001
`define BYTE_ONE    17'h00001
`define SIZE_FULL   17'h10000
`define SIZE_ZERO   16'h0000
`define STAT_PAD    4'h0
`endif

// File: core/flash_ctrl_pkg.sv
// flash_ctrl_pkg: types shared by the flash controller files.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package flash_ctrl_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] addr_t;
  typedef logic [6:0]  page_t;
  // unlock and erase sequencer
  typedef enum logic [2:0] {
    FC_LOCKED, FC_CLEARED, FC_KEY1, FC_OPEN, FC_ERASE
  } fc_state_e;
  // debug memory command framing
  typedef enum logic [3:0] {
    DB_OP, DB_AH, DB_AL, DB_SH, DB_SL,
    DB_WDAT, DB_RREQ, DB_RWAIT, DB_RSEND
  } db_state_e;
endpackage
`default_nettype wire

// File: core/page_wipe.sv
// page_wipe: strobes a write to every byte address of one page.
// assumes the flash array takes one byte write per cycle.
`include "flash_ctrl_map.svh"
`default_nettype none
module page_wipe (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // request
  input  wire logic                  start,
  input  wire flash_ctrl_pkg::page_t page,
  // write stream toward the array
  output logic                       busy,
  output logic                       we,
  output flash_ctrl_pkg::addr_t      addr,
  output logic                       done
);
  import flash_ctrl_pkg::*;

  logic [8:0] off_q;
  page_t      page_q;
  logic       busy_q;
  wire        last = off_q == `PAGE_LAST;

  // page latched at start, offset walks all bytes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      off_q  <= '0;
      page_q <= '0;
    end else if (start && !busy_q) begin
      busy_q <= 1'b1;
      off_q  <= '0;
      page_q <= page;
    end else if (busy_q) begin
      off_q <= off_q + `OFF_ONE;
      if (last) begin
        busy_q <= 1'b0;
      end
    end
  end

  // stream outputs
  assign busy = busy_q;
  assign we   = busy_q;
  assign addr = {page_q, off_q};
  assign done = busy_q && last;
endmodule
`default_nettype wire

// File: core/rd_align.sv
// rd_align: returns debug read data two cycles after the request.
// assumes both memories answer one cycle after their registered read.
`default_nettype none
module rd_align (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // request side
  input  wire logic                  re,
  input  wire logic                  dsel,
  // memory data
  input  wire flash_ctrl_pkg::byte_t fl_rdata,
  input  wire flash_ctrl_pkg::byte_t dm_rdata,
  // answer
  output logic                       rvalid,
  output flash_ctrl_pkg::byte_t      rdata
);
  import flash_ctrl_pkg::*;

  logic [1:0] v_q;
  logic [1:0] s_q;

  // two-stage valid and source pipeline
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      v_q <= '0;
      s_q <= '0;
    end else begin
      v_q <= {v_q[0], re};
      s_q <= {s_q[0], dsel};
    end
  end

  assign rvalid = v_q[1];
  assign rdata  = s_q[1] ? dm_rdata : fl_rdata;
endmodule
`default_nettype wire

// File: core/flash_unlock_program_erase_ctrl.sv
// flash controller: unlock sequence, byte program, page erase, debug
// memory commands. assumes a byte-wide flash and data memory answering
// one cycle after a read, and debug bytes already deserialised.
//
// Behaviour
// R1 - software writes 00H then the page number before any operation
// R2 - unlock needs two consecutive control writes: 73H then 8CH
// R3 - software rewrites the same page number after unlocking
// R4 - unlocked controller programs bytes from stores on the selected page
// R5 - further stores on that page program without a new unlock
// R6 - writing 00H relocks; software ends programming this way
// R7 - erase covers one page of 512 bytes
// R8 - erased page reads FFH in every byte
// R9 - erased page comes from the page select register
// R10 - 95H while unlocked and page reselected starts the erase
// R11 - processor held idle during erase; clock and peripherals run
// R12 - interrupts during erase stay pending until it ends
// R13 - finished erase returns the controller to locked
// R14 - pages in protected sectors are never erased
// R15 - no whole-array erase exists
// R16 - debug program write: 0AH, address hi/lo, size hi/lo, data
// R17 - size zero means 65536 bytes, else 1 to 65535
// R18 - debug program write data dropped unless unlocked
// R19 - debug writes dropped outside debug mode or when read-protected
// R20 - debug program read 0BH gives FFH if not debug or protected
// R21 - debug data write 0CH uses same framing into data memory
// R22 - debug data read 0DH gives FFH outside debug mode
// R23 - an out-of-order control write leaves the controller locked
`include "flash_ctrl_map.svh"
`default_nettype none
module flash_unlock_program_erase_ctrl (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // register port
  input  wire logic [3:0]            reg_addr,
  input  wire flash_ctrl_pkg::byte_t reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output flash_ctrl_pkg::byte_t      reg_rdata,
  // program memory store instructions
  input  wire logic                  cpu_st_valid,
  input  wire flash_ctrl_pkg::addr_t cpu_st_addr,
  input  wire flash_ctrl_pkg::byte_t cpu_st_data,
  output logic                       cpu_st_ready,
  output logic                       cpu_hold,
  // interrupt requests
  input  wire logic [7:0]            irq_in,
  output logic [7:0]                 irq_out,
  // debug link, bytes already deserialised
  input  wire logic                  debug_mode,
  input  wire logic                  read_protect,
  input  wire logic                  dbg_rx_valid,
  input  wire flash_ctrl_pkg::byte_t dbg_rx_byte,
  output logic                       dbg_tx_valid,
  output flash_ctrl_pkg::byte_t      dbg_tx_byte,
  input  wire logic                  dbg_tx_ready,
  // sector protection, one bit per sector
  input  wire logic [7:0]            sector_protect,
  // flash array
  output logic                       fl_we,
  output logic                       fl_re,
  output flash_ctrl_pkg::addr_t      fl_addr,
  output flash_ctrl_pkg::byte_t      fl_wdata,
  input  wire flash_ctrl_pkg::byte_t fl_rdata,
  // data memory
  output logic                       dm_we,
  output logic                       dm_re,
  output flash_ctrl_pkg::addr_t      dm_addr,
  output flash_ctrl_pkg::byte_t      dm_wdata,
  input  wire flash_ctrl_pkg::byte_t dm_rdata
);
  import flash_ctrl_pkg::*;

  // opcode decode helpers
  function automatic logic is_mem_op(input byte_t op);
    is_mem_op = (op == `OP_WR_PMEM) || (op == `OP_RD_PMEM)
             || (op == `OP_WR_DMEM) || (op == `OP_RD_DMEM);
  endfunction

  function automatic logic is_write(input byte_t op);
    is_write = (op == `OP_WR_PMEM) || (op == `OP_WR_DMEM);
  endfunction

  function automatic logic is_dmem(input byte_t op);
    is_dmem = (op == `OP_WR_DMEM) || (op == `OP_RD_DMEM);
  endfunction

  // state
  fc_state_e fc_q;
  fc_state_e fc_d;
  db_state_e db_q;
  byte_t     psel_q;
  logic      resel_q;
  byte_t     rdata_q;
  logic [7:0] held_q;
  byte_t     op_q;
  addr_t     daddr_q;
  logic [16:0] cnt_q;
  byte_t     shi_q;
  byte_t     txb_q;
  logic      fl_we_q;
  logic      fl_re_q;
  addr_t     fl_addr_q;
  byte_t     fl_wdata_q;
  logic      dm_we_q;
  logic      dm_re_q;
  addr_t     dm_addr_q;
  byte_t     dm_wdata_q;

  // submodule outputs
  logic      wipe_busy;
  logic      wipe_we;
  addr_t     wipe_addr;
  logic      wipe_done;
  logic      db_rvalid;
  byte_t     db_rdata;

  // register port decode
  wire fctl_wr  = reg_wr && (reg_addr == `REG_FCTL);
  wire psel_wr  = reg_wr && (reg_addr == `REG_PSEL);
  wire is_reset = reg_wdata == `CMD_RESET;
  wire is_key1  = reg_wdata == `CMD_KEY1;
  wire is_key2  = reg_wdata == `CMD_KEY2;
  wire is_erase = reg_wdata == `CMD_ERASE;
  wire unlocked = fc_q == FC_OPEN;
  wire erasing  = fc_q == FC_ERASE;

  // R14 sector guard
  wire page_prot = sector_protect[psel_q[`SECT_SEL]];

  // R10 erase start
  // R15 only page erase exists
  wire erase_start = unlocked && fctl_wr && is_erase && resel_q
                  && !page_prot;

  // unlock sequencer next state
  always_comb begin
    fc_d = fc_q;
    unique case (fc_q)
      FC_LOCKED: begin
        // R1 session opens with the reset write
        if (fctl_wr) begin
          fc_d = is_reset ? FC_CLEARED : FC_LOCKED;
        end
      end
      FC_CLEARED: begin
        // R2 first key
        if (fctl_wr) begin
          fc_d = is_key1 ? FC_KEY1
               : is_reset ? FC_CLEARED : FC_LOCKED;
        end
      end
      FC_KEY1: begin
        // R2 second key
        // R23 wrong order relocks
        if (fctl_wr) begin
          fc_d = is_key2 ? FC_OPEN
               : is_reset ? FC_CLEARED : FC_LOCKED;
        end
      end
      FC_OPEN: begin
        // R6 reset write relocks
        // R14 refused erase relocks
        if (erase_start) begin
          fc_d = FC_ERASE;
        end else if (fctl_wr) begin
          fc_d = is_reset ? FC_CLEARED : FC_LOCKED;
        end
      end
      FC_ERASE: begin
        // R13 relock on completion
        if (wipe_done) begin
          fc_d = FC_LOCKED;
        end
      end
      default: fc_d = FC_LOCKED;
    endcase
  end

  // sequencer, page select and reselect flag
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fc_q    <= FC_LOCKED;
      psel_q  <= '0;
      resel_q <= 1'b0;
    end else begin
      fc_q <= fc_d;
      if (psel_wr) begin
        psel_q <= reg_wdata;
      end
      // R3 page rewritten after unlocking
      // R5 flag survives while unlocked
      resel_q <= (fc_d == FC_OPEN) && (resel_q || psel_wr);
    end
  end

  // status read: protect, reselected, erasing, unlocked
  wire   reg_hit  = (reg_addr == `REG_FCTL) || (reg_addr == `REG_PSEL);
  byte_t stat;
  assign stat = {`STAT_PAD, page_prot, resel_q, erasing, unlocked};
  wire   byte_t rd_mux = (reg_addr == `REG_PSEL) ? psel_q
                       : reg_hit ? stat : `NO_BYTE;

  // read data stands for one cycle only
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : `NO_BYTE;
    end
  end
  assign reg_rdata = rdata_q;

  // R7 one page wiped per erase
  // R9 page taken from page select
  page_wipe u_wipe (
    .mclk   (mclk),
    .resetn (resetn),
    .start  (erase_start),
    .page   (psel_q[6:0]),
    .busy   (wipe_busy),
    .we     (wipe_we),
    .addr   (wipe_addr),
    .done   (wipe_done)
  );

  // debug access permissions
  // R18 program writes need the unlock
  // R19 writes need debug mode and no read protect
  wire wr_ok_d = debug_mode && !read_protect;
  wire wr_ok_p = wr_ok_d && unlocked;
  // R20 program reads blocked by either
  // R22 data reads blocked only outside debug mode
  wire rd_ok   = is_dmem(op_q) ? debug_mode : wr_ok_d;

  // debug engine strobes
  wire db_last  = cnt_q == `BYTE_ONE;
  wire db_wbyte = (db_q == DB_WDAT) && dbg_rx_valid;
  wire db_dsel  = is_dmem(op_q);
  wire db_stall = erasing;
  wire db_re    = (db_q == DB_RREQ) && !db_stall;
  wire dbg_pwe  = db_wbyte && !db_dsel && wr_ok_p;
  wire dbg_dwe  = db_wbyte && db_dsel && wr_ok_d;
  wire dbg_pre  = db_re && !db_dsel;

  // R17 zero size means the full count
  wire [15:0] size_in = {shi_q, dbg_rx_byte};
  wire [16:0] size_len = (size_in == `SIZE_ZERO) ? `SIZE_FULL
                       : {1'b0, size_in};

  // R16 framing: opcode, address, size, data
  // R21 data memory write shares the framing
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      db_q    <= DB_OP;
      op_q    <= '0;
      daddr_q <= '0;
      cnt_q   <= '0;
      shi_q   <= '0;
      txb_q   <= '0;
    end else begin
      unique case (db_q)
        DB_OP: begin
          if (dbg_rx_valid && is_mem_op(dbg_rx_byte)) begin
            op_q <= dbg_rx_byte;
            db_q <= DB_AH;
          end
        end
        DB_AH, DB_AL: begin
          if (dbg_rx_valid) begin
            daddr_q <= {daddr_q[`LO_BYTE], dbg_rx_byte};
            db_q    <= (db_q == DB_AH) ? DB_AL : DB_SH;
          end
        end
        DB_SH: begin
          if (dbg_rx_valid) begin
            shi_q <= dbg_rx_byte;
            db_q  <= DB_SL;
          end
        end
        DB_SL: begin
          if (dbg_rx_valid) begin
            cnt_q <= size_len;
            db_q  <= is_write(op_q) ? DB_WDAT : DB_RREQ;
          end
        end
        DB_WDAT: begin
          if (dbg_rx_valid) begin
            daddr_q <= daddr_q + `ADDR_ONE;
            cnt_q   <= cnt_q - `BYTE_ONE;
            if (db_last) begin
              db_q <= DB_OP;
            end
          end
        end
        DB_RREQ: begin
          if (!db_stall) begin
            db_q <= DB_RWAIT;
          end
        end
        DB_RWAIT: begin
          // R20 blocked reads give the erased value
          // R22 same for data memory
          if (db_rvalid) begin
            txb_q <= rd_ok ? db_rdata : `ERASED_BYTE;
            db_q  <= DB_RSEND;
          end
        end
        DB_RSEND: begin
          if (dbg_tx_ready) begin
            daddr_q <= daddr_q + `ADDR_ONE;
            cnt_q   <= cnt_q - `BYTE_ONE;
            db_q    <= db_last ? DB_OP : DB_RREQ;
          end
        end
        default: db_q <= DB_OP;
      endcase
    end
  end

  assign dbg_tx_valid = db_q == DB_RSEND;
  assign dbg_tx_byte  = txb_q;

  // read data return path
  rd_align u_align (
    .mclk     (mclk),
    .resetn   (resetn),
    .re       (db_re),
    .dsel     (db_dsel),
    .fl_rdata (fl_rdata),
    .dm_rdata (dm_rdata),
    .rvalid   (db_rvalid),
    .rdata    (db_rdata)
  );

  // R11 processor idles through the erase
  assign cpu_hold     = erasing || dbg_pwe || dbg_pre;
  assign cpu_st_ready = !cpu_hold;

  // R4 store on the selected page while unlocked
  wire cpu_pwe = cpu_st_valid && cpu_st_ready && unlocked && resel_q
              && (cpu_st_addr[`PAGE_HI] == psel_q[6:0]);

  // flash port select: wipe, debug, processor
  wire   fl_we_d = wipe_we || dbg_pwe || cpu_pwe;
  addr_t fl_addr_d;
  byte_t fl_wdata_d;
  // R8 wipe writes the erased value
  assign fl_addr_d  = wipe_we ? wipe_addr
                    : (dbg_pwe || dbg_pre) ? daddr_q : cpu_st_addr;
  assign fl_wdata_d = wipe_we ? `ERASED_BYTE
                    : dbg_pwe ? dbg_rx_byte : cpu_st_data;

  // registered memory strobes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fl_we_q    <= 1'b0;
      fl_re_q    <= 1'b0;
      fl_addr_q  <= '0;
      fl_wdata_q <= '0;
      dm_we_q    <= 1'b0;
      dm_re_q    <= 1'b0;
      dm_addr_q  <= '0;
      dm_wdata_q <= '0;
    end else begin
      fl_we_q    <= fl_we_d;
      fl_re_q    <= dbg_pre;
      fl_addr_q  <= fl_addr_d;
      fl_wdata_q <= fl_wdata_d;
      dm_we_q    <= dbg_dwe;
      dm_re_q    <= db_re && db_dsel;
      dm_addr_q  <= daddr_q;
      dm_wdata_q <= dbg_rx_byte;
    end
  end

  assign fl_we    = fl_we_q;
  assign fl_re    = fl_re_q;
  assign fl_addr  = fl_addr_q;
  assign fl_wdata = fl_wdata_q;
  assign dm_we    = dm_we_q;
  assign dm_re    = dm_re_q;
  assign dm_addr  = dm_addr_q;
  assign dm_wdata = dm_wdata_q;

  // R12 interrupts held during erase, released after
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      held_q <= '0;
    end else begin
      held_q <= erasing ? (held_q | irq_in) : '0;
    end
  end
  assign irq_out = erasing ? '0 : (irq_in | held_q);

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  unlock_order_a: assert property ( // R2
    (fc_q == FC_OPEN) && ($past(fc_q) != FC_OPEN) |->
      ($past(fc_q) == FC_KEY1) && $past(fctl_wr)
      && ($past(reg_wdata) == `CMD_KEY2))
    else $error("unlocked without the key pair");

  reset_relock_a: assert property ( // R6
    fctl_wr && is_reset && !erasing |=> fc_q == FC_CLEARED)
    else $error("reset write did not relock");

  bad_order_a: assert property ( // R23
    fctl_wr && !is_reset && (fc_q == FC_CLEARED) && !is_key1
      |=> fc_q == FC_LOCKED)
    else $error("out-of-order write left sequence open");

  erase_go_a: assert property ( // R10
    erase_start |=> erasing && wipe_busy)
    else $error("erase did not start");

  prot_erase_a: assert property ( // R14
    unlocked && fctl_wr && is_erase && page_prot
      |=> (fc_q == FC_LOCKED) && !wipe_busy)
    else $error("protected page erase started");

  cpu_idle_a: assert property ( // R11
    erasing |-> cpu_hold && !cpu_st_ready && !cpu_pwe)
    else $error("processor not held during erase");

  irq_defer_a: assert property ( // R12
    erasing && (irq_in[3] || held_q[3]) |=>
      (erasing && held_q[3]) || (!erasing && irq_out[3]))
    else $error("interrupt lost during erase");

  erase_relock_a: assert property ( // R13
    wipe_done |=> (fc_q == FC_LOCKED) ##1 !fl_we)
    else $error("erase did not relock");

  erase_fill_a: assert property ( // R8
    wipe_we |=> fl_we && (fl_wdata == `ERASED_BYTE)
      && (fl_addr[`PAGE_HI] == $past(wipe_addr[`PAGE_HI])))
    else $error("erase wrote a wrong byte");

  flash_gate_a: assert property ( // R18
    fl_we |-> ($past(fc_q) == FC_OPEN) || ($past(fc_q) == FC_ERASE))
    else $error("flash written while locked");
endmodule
`default_nettype wire

// File: dv/flash_mem_model.sv
// flash_mem_model: byte-wide flash array and data memory behind the
// controller. assumes one read answer in the cycle after a read strobe.
`default_nettype none
module flash_mem_model (
  // clock
  input  wire logic                  mclk,
  // flash array
  input  wire logic                  fl_we,
  input  wire logic                  fl_re,
  input  wire flash_ctrl_pkg::addr_t fl_addr,
  input  wire flash_ctrl_pkg::byte_t fl_wdata,
  output var  flash_ctrl_pkg::byte_t fl_rdata,
  // data memory
  input  wire logic                  dm_we,
  input  wire logic                  dm_re,
  input  wire flash_ctrl_pkg::addr_t dm_addr,
  input  wire flash_ctrl_pkg::byte_t dm_wdata,
  output var  flash_ctrl_pkg::byte_t dm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import flash_ctrl_pkg::*;
  byte_t fmem [0:65535];
  byte_t dmem [0:65535];
  // preload a known pattern so that erase and discard both show
  initial begin
    for (int i = 0; i < 65536; i++) begin
      fmem[i] = byte_t'(i[7:0] ^ i[15:8]);
      dmem[i] = fmem[i];
    end
    fl_rdata = 8'h00;
    dm_rdata = 8'h00;
  end
  // writes land on the edge; read data only in the answer cycle
  always @(posedge mclk) begin
    if (fl_we) fmem[fl_addr] <= fl_wdata;
    if (dm_we) dmem[dm_addr] <= dm_wdata;
    fl_rdata <= fl_re ? fmem[fl_addr] : ~fl_rdata; // churn when idle
    dm_rdata <= dm_re ? dmem[dm_addr] : ~dm_rdata;
  end
endmodule
`default_nettype wire

// File: dv/tb.sv
// tb: self-checking bench for the flash controller.
// assumes the memory model answers flash and data memory reads.
`include "flash_ctrl_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_ctrl_pkg::*;
  logic       mclk, resetn, reg_wr, reg_rd, cpu_st_valid;
  logic       cpu_st_ready, cpu_hold, debug_mode, read_protect;
  logic       dbg_rx_valid, dbg_tx_valid, fl_we, fl_re, dm_we, dm_re;
  logic [3:0] reg_addr;
  logic [7:0] irq_in, irq_out, sector_protect;
  byte_t      reg_wdata, reg_rdata, cpu_st_data, dbg_rx_byte, dbg_tx_byte;
  byte_t      fl_wdata, fl_rdata, dm_wdata, dm_rdata;
  addr_t      cpu_st_addr, fl_addr, dm_addr;
  byte_t      dbuf [0:3];
  int         error_cnt = 0, comparisons = 0, cycles = 0;
  int         we_cnt = 0, hold_cnt = 0;
  // design and memory model
  flash_unlock_program_erase_ctrl uut (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_st_valid(cpu_st_valid),
    .cpu_st_addr(cpu_st_addr), .cpu_st_data(cpu_st_data),
    .cpu_st_ready(cpu_st_ready), .cpu_hold(cpu_hold), .irq_in(irq_in),
    .irq_out(irq_out), .debug_mode(debug_mode),
    .read_protect(read_protect), .dbg_rx_valid(dbg_rx_valid),
    .dbg_rx_byte(dbg_rx_byte), .dbg_tx_valid(dbg_tx_valid),
    .dbg_tx_byte(dbg_tx_byte), .dbg_tx_ready(1'b1),
    .sector_protect(sector_protect), .fl_we(fl_we), .fl_re(fl_re),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rdata(fl_rdata),
    .dm_we(dm_we), .dm_re(dm_re), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));
  flash_mem_model mem (.mclk(mclk), .fl_we(fl_we), .fl_re(fl_re),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rdata(fl_rdata),
    .dm_we(dm_we), .dm_re(dm_re), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));
  // clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // write and hold counters, hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (fl_we === 1'b1) we_cnt <= we_cnt + 1;
    if (cpu_hold === 1'b1) hold_cnt <= hold_cnt + 1;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic byte_t pat(input addr_t a);
    return a[7:0] ^ a[15:8];
  endfunction
  // register port cycles
  task automatic wr(input logic [3:0] a, input byte_t d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic status(output byte_t v);
    @(posedge mclk);
    reg_addr <= `REG_FCTL;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // software reset, page, two keys, page again
  task automatic unlock(input page_t p);
    wr(`REG_FCTL, `CMD_RESET);
    wr(`REG_PSEL, {1'b0, p});
    wr(`REG_FCTL, `CMD_KEY1);
    wr(`REG_FCTL, `CMD_KEY2);
    wr(`REG_PSEL, {1'b0, p});
  endtask
  task automatic store(input addr_t a, input byte_t d);
    @(posedge mclk);
    cpu_st_valid <= 1'b1;
    cpu_st_addr <= a;
    cpu_st_data <= d;
    @(posedge mclk);
    cpu_st_valid <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // one debug byte, spaced pulses
  task automatic dsend(input byte_t b);
    @(posedge mclk);
    dbg_rx_valid <= 1'b1;
    dbg_rx_byte <= b;
    @(posedge mclk);
    dbg_rx_valid <= 1'b0;
  endtask
  // debug framing: writes send dbuf, reads fill dbuf
  task automatic dcmd(input byte_t op, input addr_t a, input byte_t n);
    int t;
    dsend(op);
    dsend(a[15:8]);
    dsend(a[7:0]);
    dsend(8'h00);
    dsend(n);
    for (int i = 0; i < int'(n); i++) begin
      if (op == `OP_WR_PMEM || op == `OP_WR_DMEM) dsend(dbuf[i]);
      else begin
        t = 0;
        @(negedge mclk);
        while (dbg_tx_valid !== 1'b1 && t < 50) begin
          @(negedge mclk);
          t++;
        end
        dbuf[i] = dbg_tx_byte;
        @(posedge mclk);
      end
    end
    repeat (4) @(posedge mclk);
  endtask
  task automatic t_lock();
    byte_t v;
    wr(`REG_FCTL, `CMD_RESET);
    wr(`REG_FCTL, `CMD_KEY1);
    wr(`REG_FCTL, `CMD_ERASE);
    wr(`REG_FCTL, `CMD_KEY2);
    status(v);
    check("broken order", 16'(v[2:0]), 16'h0000);
    unlock(7'd3);
    status(v);
    check("unlocked", 16'(v[2:0]), 16'h0005);
    wr(`REG_FCTL, `CMD_RESET);
    status(v);
    check("relocked", 16'(v[0]), 16'h0000);
  endtask
  task automatic t_store();
    unlock(7'd3);
    store(16'h0610, 8'h77);
    store(16'h0611, 8'h88);
    store(16'h0810, 8'h99);
    check("store", 16'(mem.fmem[16'h0610]), 16'h0077);
    check("store next", 16'(mem.fmem[16'h0611]), 16'h0088);
    check("other page", 16'(mem.fmem[16'h0810]), 16'(pat(16'h0810)));
    wr(`REG_FCTL, `CMD_RESET);
    store(16'h0612, 8'h55);
    check("locked", 16'(mem.fmem[16'h0612]), 16'(pat(16'h0612)));
  endtask
  task automatic t_erase(input page_t p, input logic ok);
    int w0, h0, n;
    byte_t v;
    unlock(p);
    w0 = we_cnt;
    h0 = hold_cnt;
    wr(`REG_FCTL, `CMD_ERASE);
    irq_in <= 8'h08;
    #1 check("irq in erase", 16'(irq_out), ok ? 16'h0000 : 16'h0008);
    @(posedge mclk);
    irq_in <= 8'h00;
    #1 n = 0;
    while (cpu_hold === 1'b1 && n < 600) begin
      @(posedge mclk);
      #1 n++;
    end
    check("irq after", 16'(irq_out), ok ? 16'h0008 : 16'h0000);
    repeat (3) @(posedge mclk);
    check("wipes", 16'(we_cnt - w0), ok ? 16'd512 : 16'd0);
    check("hold", 16'(hold_cnt - h0), ok ? 16'd512 : 16'd0);
    n = 0;
    for (int i = 0; i < 512; i++)
      if (mem.fmem[{p, 9'(i)}] !== (ok ? 8'hFF : pat({p, 9'(i)}))) n++;
    check("page bytes", 16'(n), 16'h0000);
    check("next page", 16'(mem.fmem[{p + 7'd1, 9'h000}]),
          16'(pat({p + 7'd1, 9'h000})));
    status(v);
    check("locked after", 16'(v[1:0]), 16'h0000);
  endtask
  task automatic t_debug();
    unlock(7'd5);
    dbuf[0] = 8'hA1;
    dbuf[1] = 8'hB2;
    dcmd(`OP_WR_PMEM, 16'h0A10, 8'h02);
    wr(`REG_FCTL, `CMD_RESET);
    dbuf[0] = 8'hC3;
    dcmd(`OP_WR_PMEM, 16'h0A12, 8'h01);
    check("pwrite", {mem.fmem[16'h0A10], mem.fmem[16'h0A11]}, 16'hA1B2);
    check("pw locked", 16'(mem.fmem[16'h0A12]), 16'h00FF);
    dcmd(`OP_RD_PMEM, 16'h0A10, 8'h02);
    check("pread", {dbuf[0], dbuf[1]}, 16'hA1B2);
    read_protect <= 1'b1;
    dcmd(`OP_RD_PMEM, 16'h0A10, 8'h02);
    check("pread prot", {dbuf[0], dbuf[1]}, 16'hFFFF);
    dbuf[0] = 8'h3C;
    dcmd(`OP_WR_DMEM, 16'h0040, 8'h01);
    check("dw prot", 16'(mem.dmem[16'h0040]), 16'(pat(16'h0040)));
    read_protect <= 1'b0;
    dcmd(`OP_WR_DMEM, 16'h0040, 8'h01);
    check("dwrite", 16'(mem.dmem[16'h0040]), 16'h003C);
    read_protect <= 1'b1;
    dcmd(`OP_RD_DMEM, 16'h0040, 8'h01);
    check("dread prot", 16'(dbuf[0]), 16'h003C);
    debug_mode <= 1'b0;
    read_protect <= 1'b0;
    dcmd(`OP_RD_DMEM, 16'h0040, 8'h01);
    check("dread off", 16'(dbuf[0]), 16'h00FF);
    dbuf[0] = 8'h11;
    dcmd(`OP_WR_DMEM, 16'h0041, 8'h01);
    check("dw off", 16'(mem.dmem[16'h0041]), 16'(pat(16'h0041)));
  endtask
  // reset, then the scenarios
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    cpu_st_valid = 1'b0;
    cpu_st_addr = 16'h0000;
    cpu_st_data = 8'h00;
    irq_in = 8'h00;
    debug_mode = 1'b1;
    read_protect = 1'b0;
    dbg_rx_valid = 1'b0;
    dbg_rx_byte = 8'h00;
    sector_protect = 8'h02;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    t_lock();
    t_store();
    t_erase(7'd5, 1'b1);
    t_erase(7'd20, 1'b0);
    t_debug();
    conclude();
  end
endmodule
`default_nettype wire
